// [teg_pkg.sv]
// Constants and types of the trace element generator.
// Assumes one core clock; core and encoder sit in the same clock domain.
// Summary of operation
// - Taken gives atom or source address; not taken gives atom or nothing
// - Atoms are speculative and later resolved by commit or cancel elements
// - After elided not-taken atom, next taken flow gives source address
// - Source address element carries the address of the taken flow change
// - Every count element is followed by a target address element
// - Count ending on a flow change: target address is its branch target
// - Count not ending on a flow change: target is next sequential address
// - Count element never implies instructions past the permitted region end
// - Entry into a count region is traced with non-count elements
// - Sequential entry count never implies flow changes outside the region
// - Enabled channel with active resource gives events while operative
// - Pending events go out within a bounded number of flow elements
// - During buffer overflow, events are output before the overflow element
// - Cancellation gives a cancel element, kept in order with flow elements
// - Cancel to non-adjacent point is followed by an exception element
// - Resolution of flow elements as executed gives a commit element
// - Outstanding speculative elements never exceed the speculation depth
// - On disable all pending commit elements are output first
// - Commit with cycle count is never merged with later commits
// - Outer transaction entry gives start element before its instructions
// - Leaving started transaction gives commit, failure or cancel of start
// - Transaction commit follows earlier flow element, precedes next start
// - Txn failure, prohibit, reset, disable or overflow give failure element
// - Transaction failure is an exception element of failure type
package teg_pkg;
  localparam int ADDR_W     = 64;
  localparam int INFO_W     = 8;
  localparam int EV_N       = 4;
  localparam int MAX_SPEC   = 16;
  localparam int SPEC_W     = 5;
  localparam int EVENT_LAG  = 2;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [3:0]
  {
    EL_NONE      = 4'h0,
    EL_ATOM_E    = 4'h1,
    EL_ATOM_N    = 4'h2,
    EL_SRC_ADDR  = 4'h3,
    EL_COUNT     = 4'h4,
    EL_TGT_ADDR  = 4'h5,
    EL_EXCEPTION = 4'h6,
    EL_CANCEL    = 4'h7,
    EL_COMMIT    = 4'h8,
    EL_EVENT     = 4'h9,
    EL_TX_START  = 4'hA,
    EL_TX_COMMIT = 4'hB,
    EL_OVERFLOW  = 4'hC
  } teg_elem_e;

  typedef enum logic [3:0]
  {
    OP_FLOW      = 4'h0,
    OP_COUNT     = 4'h1,
    OP_EXCEPTION = 4'h2,
    OP_CANCEL    = 4'h3,
    OP_TX_START  = 4'h4,
    OP_TX_COMMIT = 4'h5,
    OP_TX_FAIL   = 4'h6,
    OP_RESET     = 4'h7,
    OP_PROHIBIT  = 4'h8
  } teg_op_e;

  typedef enum logic [4:0]
  {
    ST_RUN    = 5'h01,
    ST_SECOND = 5'h02,
    ST_FLUSH  = 5'h04,
    ST_OVF    = 5'h08,
    ST_OFF    = 5'h10
  } teg_state_e;

  // Exception type field values
  localparam logic [INFO_W-1:0] EXC_TX_FAIL = 8'h01;
  localparam logic [INFO_W-1:0] EXC_RESET   = 8'h02;
  localparam logic [INFO_W-1:0] EXC_RESUME  = 8'h03;
  // Bit of the address field that flags a commit with cycle count
  localparam int CC_BIT = 0;
endpackage

// [teg_generator.sv]
// Trace element generator with its output FIFO.
// Assumes core, configuration and encoder all run on clk; no synchronisers.

module teg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int LW    = $clog2(DEPTH) + 1
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [LW-1:0]         level
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [IW-1:0]    wr_idx, rd_idx;
  logic             push, pop;

  function automatic logic [IW-1:0] idx_inc(input logic [IW-1:0] i);
    idx_inc = (i == IW'(DEPTH - 1)) ? '0 : IW'(i + 1'b1);
  endfunction

  assign in_ready  = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_idx];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      level  <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_idx <= idx_inc(wr_idx);
      if (pop)
        rd_idx <= idx_inc(rd_idx);
      if (push && !pop)
        level <= LW'(level + 1'b1);
      else if (pop && !push)
        level <= LW'(level - 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_idx] <= in_data;
  end
endmodule

module teg_generator
  import teg_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              trace_enable,
  input  wire logic              overflow,
  input  wire logic              instruction_trace_filter,
  input  wire logic              elide_not_taken,
  input  wire logic [EV_N-1:0]   event_instruction_enable,
  input  wire logic [EV_N-1:0]   event_resource_active,
  input  wire logic              core_valid,
  output logic                   core_ready,
  input  wire teg_op_e           core_op,
  input  wire logic              core_taken,
  input  wire logic              core_entry,
  input  wire logic              core_nonadj,
  input  wire logic              core_cancel_tx,
  input  wire logic [INFO_W-1:0] core_count,
  input  wire logic [INFO_W-1:0] core_region_left,
  input  wire logic              core_last_is_flow,
  input  wire logic [ADDR_W-1:0] core_addr,
  input  wire logic [ADDR_W-1:0] core_target,
  input  wire logic [ADDR_W-1:0] core_next_addr,
  input  wire logic [ADDR_W-1:0] core_region_end,
  input  wire logic [INFO_W-1:0] core_info,
  input  wire logic              commit_valid,
  output logic                   commit_ready,
  input  wire logic [INFO_W-1:0] commit_count,
  input  wire logic              commit_has_cc,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output teg_elem_e              out_type,
  output logic [INFO_W-1:0]      out_info,
  output logic [ADDR_W-1:0]      out_addr
);
  localparam int EW = 4 + INFO_W + ADDR_W;
  localparam int LW = $clog2(DEPTH) + 1;

  teg_state_e        state, next_state;
  logic [SPEC_W-1:0] spec, next_spec;
  logic              skip_nt, next_skip_nt, commit_cc, set_sec;
  logic              tx_active, tx_started, next_tx_active, next_tx_started;
  logic [EV_N-1:0]   ev_pend, ev_now;
  logic [1:0]        ev_lag;
  teg_elem_e         sec_type, n_sec_type, p_type;
  logic [INFO_W-1:0] sec_info, n_sec_info, p_info, spec_dec;
  logic [INFO_W-1:0] commit_acc, cnt_clamp;
  logic [ADDR_W-1:0] sec_addr, n_sec_addr, p_addr;
  logic              push, spec_inc, take_commit, take_ev, flow_push;
  logic              core_fire, commit_fire, fifo_in_ready, fifo_pop;
  logic              fifo_out_valid;
  logic [EW-1:0]     fifo_out_data;
  logic [LW-1:0]     fifo_level;
  logic [LW:0]       lvl_next;

  function automatic logic [SPEC_W-1:0] sat_sub(input logic [SPEC_W-1:0] a,
                                                input logic [INFO_W-1:0] b);
    sat_sub = ({3'h0, a} > b) ? SPEC_W'({3'h0, a} - b) : '0;
  endfunction

  assign core_fire   = core_valid && core_ready;
  assign commit_fire = commit_valid && commit_ready;
  // Events run whether or not instructions are selected
  assign ev_now      = event_instruction_enable & event_resource_active
                       & {EV_N{(state == ST_RUN) || (state == ST_SECOND)
                               || (state == ST_OVF)}};
  assign cnt_clamp   = (core_count > core_region_left) ? core_region_left
                                                       : core_count;

  always_comb
  begin
    next_state      = state;
    next_skip_nt    = skip_nt;
    next_tx_active  = tx_active;
    next_tx_started = tx_started;
    {push, set_sec, spec_inc, take_commit, take_ev, flow_push} = '0;
    {p_info, p_addr, n_sec_info, n_sec_addr} = '0;
    p_type          = EL_NONE;
    n_sec_type      = EL_NONE;
    spec_dec        = commit_fire ? commit_count : '0;
    case (state)
      ST_RUN:
      begin
        if (!trace_enable)
          next_state = ST_FLUSH;
        else if (overflow)
          next_state = ST_OVF;
        if (core_fire)
        begin
          case (core_op)
            OP_FLOW:
            if (instruction_trace_filter)
            begin
              if (core_taken)
              begin
                push     = 1'b1;
                spec_inc = 1'b1;
                if (skip_nt)
                begin
                  p_type       = EL_SRC_ADDR;
                  p_addr       = core_addr;
                  next_skip_nt = 1'b0;
                end
                else
                  p_type = EL_ATOM_E;
              end
              else if (elide_not_taken)
                next_skip_nt = 1'b1;
              else
              begin
                push     = 1'b1;
                spec_inc = 1'b1;
                p_type   = EL_ATOM_N;
              end
            end
            OP_COUNT:
            if (instruction_trace_filter)
            begin
              push = 1'b1;
              if (core_entry)
              begin
                // Entering instruction is never folded into a count
                p_type   = EL_ATOM_E;
                spec_inc = 1'b1;
              end
              else
              begin
                p_type     = EL_COUNT;
                p_info     = cnt_clamp;
                set_sec    = 1'b1;
                next_state = ST_SECOND;
                n_sec_type = EL_TGT_ADDR;
                if (core_count > core_region_left)
                  n_sec_addr = core_region_end;
                else if (core_last_is_flow)
                  n_sec_addr = core_target;
                else
                  n_sec_addr = core_next_addr;
              end
            end
            OP_EXCEPTION:
            begin
              push         = instruction_trace_filter;
              p_type       = EL_EXCEPTION;
              p_info       = core_info;
              p_addr       = core_addr;
              next_skip_nt = 1'b0;
            end
            OP_CANCEL:
            begin
              push     = 1'b1;
              p_type   = EL_CANCEL;
              p_info   = core_count;
              spec_dec = INFO_W'(spec_dec + core_count);
              if (core_cancel_tx)
                next_tx_started = 1'b0;
              if (core_nonadj)
              begin
                set_sec    = 1'b1;
                next_state = ST_SECOND;
                n_sec_type = EL_EXCEPTION;
                n_sec_info = EXC_RESUME;
                n_sec_addr = core_addr;
              end
            end
            OP_TX_START:
            begin
              next_tx_active = 1'b1;
              if (!tx_active && instruction_trace_filter)
              begin
                push            = 1'b1;
                p_type          = EL_TX_START;
                next_tx_started = 1'b1;
              end
            end
            OP_TX_COMMIT:
            begin
              next_tx_active  = 1'b0;
              next_tx_started = 1'b0;
              push            = tx_started;
              p_type          = EL_TX_COMMIT;
            end
            OP_TX_FAIL, OP_PROHIBIT:
            begin
              next_tx_active  = (core_op == OP_PROHIBIT) && tx_active;
              next_tx_started = 1'b0;
              push            = tx_started;
              p_type          = EL_EXCEPTION;
              p_info          = EXC_TX_FAIL;
            end
            OP_RESET:
            begin
              next_tx_active  = 1'b0;
              next_tx_started = 1'b0;
              next_skip_nt    = 1'b0;
              push            = 1'b1;
              p_type          = EL_EXCEPTION;
              p_addr          = core_addr;
              if (tx_started)
              begin
                p_info     = EXC_TX_FAIL;
                set_sec    = 1'b1;
                next_state = ST_SECOND;
                n_sec_type = EL_EXCEPTION;
                n_sec_info = EXC_RESET;
                n_sec_addr = core_addr;
              end
              else
                p_info = EXC_RESET;
            end
            default:
              push = 1'b0;
          endcase
          flow_push = push;
        end
        else if (fifo_in_ready && (commit_acc != '0))
        begin
          push        = 1'b1;
          take_commit = 1'b1;
          p_type      = EL_COMMIT;
          p_info      = commit_acc;
          p_addr[CC_BIT] = commit_cc;
        end
        else if (fifo_in_ready && (ev_pend != '0))
        begin
          push    = 1'b1;
          take_ev = 1'b1;
          p_type  = EL_EVENT;
          p_info  = INFO_W'(ev_pend);
        end
      end
      ST_SECOND:
      if (fifo_in_ready)
      begin
        push       = 1'b1;
        p_type     = sec_type;
        p_info     = sec_info;
        p_addr     = sec_addr;
        next_state = ST_RUN;
      end
      ST_FLUSH:
      if (fifo_in_ready)
      begin
        push = 1'b1;
        if (commit_acc != '0)
        begin
          take_commit    = 1'b1;
          p_type         = EL_COMMIT;
          p_info         = commit_acc;
          p_addr[CC_BIT] = commit_cc;
        end
        else if (tx_started)
        begin
          next_tx_started = 1'b0;
          p_type          = EL_EXCEPTION;
          p_info          = EXC_TX_FAIL;
        end
        else
        begin
          push       = 1'b0;
          next_state = ST_OFF;
        end
      end
      ST_OVF:
      if (fifo_in_ready)
      begin
        push = 1'b1;
        if (ev_pend != '0)
        begin
          take_ev = 1'b1;
          p_type  = EL_EVENT;
          p_info  = INFO_W'(ev_pend);
        end
        else if (tx_started)
        begin
          next_tx_started = 1'b0;
          p_type          = EL_EXCEPTION;
          p_info          = EXC_TX_FAIL;
        end
        else if (ev_now == '0)
        begin
          p_type     = EL_OVERFLOW;
          next_state = ST_OFF;
        end
        else
          push = 1'b0;
      end
      ST_OFF:
      if (trace_enable && !overflow)
        next_state = ST_RUN;
      default:
        next_state = ST_OFF;
    endcase
  end

  assign next_spec = sat_sub(SPEC_W'(spec + spec_inc), spec_dec);
  assign lvl_next  = (LW + 1)'(fifo_level + push - fifo_pop);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state      <= ST_OFF;
      skip_nt    <= 1'b0;
      tx_active  <= 1'b0;
      tx_started <= 1'b0;
      spec       <= '0;
    end
    else if (ce)
    begin
      state      <= next_state;
      skip_nt    <= next_skip_nt;
      tx_active  <= next_tx_active;
      tx_started <= next_tx_started;
      spec       <= next_spec;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sec_type <= EL_NONE;
      sec_info <= '0;
      sec_addr <= '0;
    end
    else if (ce && set_sec)
    begin
      sec_type <= n_sec_type;
      sec_info <= n_sec_info;
      sec_addr <= n_sec_addr;
    end
  end

  // Commits merge until one carrying a cycle count arrives
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      commit_acc   <= '0;
      commit_cc    <= 1'b0;
      commit_ready <= 1'b0;
    end
    else if (ce)
    begin
      commit_acc   <= INFO_W'((take_commit ? '0 : commit_acc)
                       + (commit_fire ? commit_count : '0));
      commit_cc    <= (!take_commit && commit_cc)
                      || (commit_fire && commit_has_cc);
      commit_ready <= !((!take_commit && commit_cc) || commit_fire);
    end
  end

  // New events win over the clear of the same cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_pend <= '0;
      ev_lag  <= '0;
    end
    else if (ce)
    begin
      ev_pend <= (take_ev ? '0 : ev_pend) | ev_now;
      if (take_ev || (ev_pend == '0))
        ev_lag <= '0;
      else if (flow_push && (ev_lag != 2'(EVENT_LAG)))
        ev_lag <= 2'(ev_lag + 1'b1);
    end
  end

  // Ready leaves room for an item and its follow-on element
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      core_ready <= 1'b0;
    else if (ce)
      core_ready <= (next_state == ST_RUN) && !core_fire
                    && (lvl_next <= (LW + 1)'(DEPTH - 2))
                    && (next_spec < SPEC_W'(MAX_SPEC))
                    && (ev_lag != 2'(EVENT_LAG));
  end

  teg_fifo #(
    .WIDTH (EW),
    .DEPTH (DEPTH),
    .LW    (LW)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({p_type, p_info, p_addr}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  assign fifo_pop = fifo_out_valid && (!out_valid || out_ready);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_valid <= 1'b0;
      out_type  <= EL_NONE;
      out_info  <= '0;
      out_addr  <= '0;
    end
    else if (ce)
    begin
      if (fifo_pop)
      begin
        out_valid <= 1'b1;
        out_type  <= teg_elem_e'(fifo_out_data[EW-1 -: 4]);
        out_info  <= fifo_out_data[ADDR_W +: INFO_W];
        out_addr  <= fifo_out_data[ADDR_W-1:0];
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule

// [teg_checker.sv]
// Assertion checker for the trace element generator output stream.
// Sees only the generator's ports; bound to every generator instance.
module teg_checker
  import teg_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic              core_valid,
  input wire logic              core_ready,
  input wire logic              commit_valid,
  input wire logic              commit_ready,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire teg_elem_e         out_type,
  input wire logic [INFO_W-1:0] out_info,
  input wire logic [ADDR_W-1:0] out_addr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic      hs, fail, tx_open, tx_maybe;
  teg_elem_e prev;

  assign hs   = ce && out_valid && out_ready;
  assign fail = out_type == EL_EXCEPTION && out_info == EXC_TX_FAIL;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      prev <= EL_NONE;
    else if (hs)
      prev <= out_type;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      tx_open <= 1'h0;
    else if (hs)
      tx_open <= out_type == EL_TX_START ||
                 (tx_open && out_type != EL_TX_COMMIT && !fail);

  // A cancel may remove the start, so it only closes this weaker flag
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      tx_maybe <= 1'h0;
    else if (hs)
      tx_maybe <= out_type == EL_TX_START || (tx_maybe && !fail &&
                  !(out_type inside {EL_TX_COMMIT, EL_CANCEL}));

  AST_TGT_AFTER_COUNT: assert property (
    hs && prev == EL_COUNT |-> out_type == EL_TGT_ADDR)
    else $error("count lacks target");
  AST_RESUME_AFTER_CANCEL: assert property (
    hs && out_type == EL_EXCEPTION && out_info == EXC_RESUME
    |-> prev == EL_CANCEL)
    else $error("stray resume");
  AST_TX_COMMIT_OPEN: assert property (
    hs && out_type == EL_TX_COMMIT |-> tx_open)
    else $error("commit without start");
  AST_FAIL_OPEN: assert property (
    hs && fail |-> tx_open)
    else $error("failure without start");
  AST_START_CLOSED: assert property (
    hs && out_type == EL_TX_START |-> !tx_maybe)
    else $error("start while open");
  AST_OUT_HOLD: assert property (
    ce && out_valid && !out_ready |=> out_valid && $stable(out_type)
    && $stable(out_info) && $stable(out_addr))
    else $error("output moved in stall");
  AST_CORE_GAP: assert property (
    ce && core_valid && core_ready |=> !core_ready)
    else $error("core ready after take");
  AST_COMMIT_GAP: assert property (
    ce && commit_valid && commit_ready |=> !commit_ready)
    else $error("commit ready after take");
endmodule

bind teg_generator teg_checker u_teg_checker (.*);

// [teg_core_model.sv]
// Behavioural processor core driving the generator's core port.
// Assumes requests launch on falling edges and ready is a flop.
module teg_core_model
  import teg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        core_ready,
  output logic             core_valid,
  output teg_op_e          core_op,
  output logic             core_taken,
  output logic             core_entry,
  output logic             core_nonadj,
  output logic             core_cancel_tx,
  output logic [INFO_W-1:0] core_count,
  output logic [INFO_W-1:0] core_region_left,
  output logic             core_last_is_flow,
  output logic [ADDR_W-1:0] core_addr,
  output logic [ADDR_W-1:0] core_target,
  output logic [ADDR_W-1:0] core_next_addr,
  output logic [ADDR_W-1:0] core_region_end,
  output logic [INFO_W-1:0] core_info
);
  int taken_n = 0;

  initial
  begin
    core_op = OP_FLOW;
    {core_valid, core_taken, core_entry, core_nonadj, core_cancel_tx,
     core_last_is_flow, core_count, core_region_left, core_info, core_addr,
     core_target, core_next_addr, core_region_end} = '0;
  end

  task automatic send(input teg_op_e o, input logic [3:0] f,
                      input logic [INFO_W-1:0] n, l,
                      input logic [ADDR_W-1:0] a, t);
    int w;
    w = 0;
    @(negedge clk);
    core_op = o;
    {core_taken, core_entry, core_nonadj, core_last_is_flow} = f;
    core_count = n;
    core_info = n;
    core_region_left = l;
    core_addr = a;
    core_target = t;
    core_next_addr = a + 64'h4;
    core_region_end = t + 64'h10;
    core_valid = 1'h1;
    while (!core_ready && w < 400)
    begin
      @(negedge clk);
      w++;
    end
    @(posedge clk);
    taken_n++;
    @(negedge clk);
    core_valid = 1'h0;
    // Released address and target lines must not keep the old value
    core_addr = ~a;
    core_target = ~t;
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the trace element generator.
// Assumes the core model on the core port; bench drives the rest.
module tb
  import teg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'h0, rst_b = 1'h0, ce = 1'h1, overflow = 1'h0;
  logic trace_enable = 1'h1, instruction_trace_filter = 1'h1;
  logic elide_not_taken = 1'h0, commit_valid = 1'h0, commit_has_cc = 1'h0;
  logic [EV_N-1:0] event_instruction_enable = '0;
  logic [EV_N-1:0] event_resource_active = '0;
  logic [INFO_W-1:0] commit_count = '0;
  logic out_ready = 1'h1;
  logic core_valid, core_ready, core_taken, core_entry, core_nonadj;
  logic core_cancel_tx, core_last_is_flow, commit_ready, out_valid;
  teg_op_e core_op;
  teg_elem_e out_type;
  logic [INFO_W-1:0] core_count, core_region_left, core_info, out_info;
  logic [ADDR_W-1:0] core_addr, core_target, core_next_addr;
  logic [ADDR_W-1:0] core_region_end, out_addr;
  logic [75:0] q[$];
  int mismatches = 0, compares = 0, cycles = 0;

  teg_core_model u_teg_core_model (.*);
  teg_generator u_teg_generator (.*);

  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    if (rst_b && out_valid && out_ready)
      q.push_back({out_type, out_info, out_addr});
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("[FAIL] %0t run did not finish", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp_t(input teg_elem_e g, e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t element %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic cmp_v(input logic [ADDR_W-1:0] g, e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t value %0h expected %0h", $time, g, e);
    end
  endtask

  // Field select: 1 address, 2 info, 3 info with cycle-count flag
  task automatic ex(input teg_elem_e t, input int s,
                    input logic [ADDR_W-1:0] v);
    logic [75:0] x;
    int w;
    w = 0;
    while (q.size() == 0 && w < 300)
    begin
      @(negedge clk);
      w++;
    end
    x = q.size() > 0 ? q.pop_front() : '0;
    cmp_t(teg_elem_e'(x[75:72]), t);
    if (s == 1)
      cmp_v(x[63:0], v);
    if (s == 2)
      cmp_v({56'h0, x[71:64]}, v);
    if (s == 3)
      cmp_v({55'h0, x[71:64], x[0]}, v);
  endtask

  task automatic sd(input teg_op_e o, input logic [3:0] f,
                    input logic [INFO_W-1:0] n, l,
                    input logic [ADDR_W-1:0] a);
    u_teg_core_model.send(o, f, n, l, a, a + 64'h100);
  endtask

  task automatic commit(input logic [INFO_W-1:0] n, input logic c);
    int w;
    w = 0;
    @(negedge clk);
    commit_count = n;
    commit_has_cc = c;
    commit_valid = 1'h1;
    while (!commit_ready && w < 300)
    begin
      @(negedge clk);
      w++;
    end
    @(negedge clk);
    commit_valid = 1'h0;
    commit_count = ~n;
  endtask

  task automatic s_flow();
    sd(OP_FLOW, 4'h8, 8'h0, 8'h0, 64'h100);
    sd(OP_FLOW, 4'h0, 8'h0, 8'h0, 64'h104);
    elide_not_taken = 1'h1;
    sd(OP_FLOW, 4'h0, 8'h0, 8'h0, 64'h108);
    sd(OP_FLOW, 4'h8, 8'h0, 8'h0, 64'h10C);
    elide_not_taken = 1'h0;
    ex(EL_ATOM_E, 0, 64'h0);
    ex(EL_ATOM_N, 0, 64'h0);
    ex(EL_SRC_ADDR, 1, 64'h10C);
  endtask

  task automatic s_cancel();
    sd(OP_CANCEL, 4'h0, 8'h1, 8'h0, 64'h200);
    sd(OP_CANCEL, 4'h2, 8'h1, 8'h0, 64'h204);
    ex(EL_CANCEL, 0, 64'h0);
    ex(EL_CANCEL, 0, 64'h0);
    ex(EL_EXCEPTION, 2, 64'h3);
    commit(8'h1, 1'h0);
    ex(EL_COMMIT, 3, 64'h2);
  endtask

  task automatic s_count();
    sd(OP_COUNT, 4'h1, 8'h5, 8'h20, 64'h300);
    sd(OP_COUNT, 4'h0, 8'h3, 8'h20, 64'h500);
    sd(OP_COUNT, 4'h0, 8'h9, 8'h3, 64'h600);
    sd(OP_COUNT, 4'h4, 8'h2, 8'h20, 64'h800);
    ex(EL_COUNT, 2, 64'h5);
    ex(EL_TGT_ADDR, 1, 64'h400);
    ex(EL_COUNT, 2, 64'h3);
    ex(EL_TGT_ADDR, 1, 64'h504);
    ex(EL_COUNT, 2, 64'h3);
    ex(EL_TGT_ADDR, 1, 64'h710);
    ex(EL_ATOM_E, 0, 64'h0);
    commit(8'h1, 1'h0);
    ex(EL_COMMIT, 3, 64'h2);
  endtask

  task automatic s_event();
    instruction_trace_filter = 1'h0;
    sd(OP_FLOW, 4'h8, 8'h0, 8'h0, 64'hA00);
    event_resource_active = 4'h7;
    event_instruction_enable = 4'hD;
    @(negedge clk);
    event_instruction_enable = 4'h0;
    ex(EL_EVENT, 2, 64'h5);
    instruction_trace_filter = 1'h1;
  endtask

  task automatic s_tx();
    sd(OP_TX_START, 4'h0, 8'h0, 8'h0, 64'hB00);
    sd(OP_FLOW, 4'h8, 8'h0, 8'h0, 64'hB04);
    sd(OP_TX_COMMIT, 4'h0, 8'h0, 8'h0, 64'hB08);
    sd(OP_TX_START, 4'h0, 8'h0, 8'h0, 64'hB0C);
    sd(OP_TX_FAIL, 4'h0, 8'h0, 8'h0, 64'hB10);
    sd(OP_TX_START, 4'h0, 8'h0, 8'h0, 64'hB14);
    sd(OP_RESET, 4'h0, 8'h0, 8'h0, 64'hB18);
    ex(EL_TX_START, 0, 64'h0);
    ex(EL_ATOM_E, 0, 64'h0);
    ex(EL_TX_COMMIT, 0, 64'h0);
    ex(EL_TX_START, 0, 64'h0);
    ex(EL_EXCEPTION, 2, 64'h1);
    ex(EL_TX_START, 0, 64'h0);
    ex(EL_EXCEPTION, 2, 64'h1);
    ex(EL_EXCEPTION, 2, 64'h2);
  endtask

  task automatic s_stall();
    int b;
    b = u_teg_core_model.taken_n;
    out_ready = 1'h0;
    fork
      repeat (6) sd(OP_FLOW, 4'h8, 8'h0, 8'h0, 64'hC00);
      begin
        repeat (40) @(negedge clk);
        cmp_v(64'(u_teg_core_model.taken_n - b < 6), 64'h1);
        out_ready = 1'h1;
      end
    join
    repeat (6) ex(EL_ATOM_E, 0, 64'h0);
    commit(8'h4, 1'h1);
    commit(8'h2, 1'h0);
    ex(EL_COMMIT, 3, 64'h9);
    ex(EL_COMMIT, 3, 64'h4);
  endtask

  task automatic s_off();
    sd(OP_TX_START, 4'h0, 8'h0, 8'h0, 64'hD00);
    sd(OP_FLOW, 4'h8, 8'h0, 8'h0, 64'hD04);
    commit(8'h1, 1'h0);
    trace_enable = 1'h0;
    ex(EL_TX_START, 0, 64'h0);
    ex(EL_ATOM_E, 0, 64'h0);
    ex(EL_COMMIT, 3, 64'h2);
    ex(EL_EXCEPTION, 2, 64'h1);
  endtask

  initial
  begin
    repeat (2) @(negedge clk);
    rst_b = 1'h1;
    repeat (3) @(negedge clk);
    s_flow();
    s_cancel();
    s_count();
    s_event();
    s_tx();
    s_stall();
    s_off();
    test_done();
  end
endmodule
